// *** hdl/rss_stream_core.sv ***
// Request sideband handling and completion return stream with Avalon regs
`timescale 1ns/1ps
module rss_stream_core (
   input wire logic core_clk,
   input wire logic reset,
   // Avalon-MM register slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Request stream from user logic
   input wire logic req_in_valid,
   output logic req_in_ready,
   input wire logic [511:0] req_in_payload,
   input wire logic [182:0] req_in_sideband,
   input wire logic req_in_last,
   input wire logic req_in_dual_start,
   input wire logic [5:0] req_tag_first,
   // Request stream toward the link
   output logic link_req_valid,
   input wire logic link_req_ready,
   output logic [511:0] link_req_payload,
   output logic [182:0] link_req_sideband,
   output logic link_req_last,
   output logic link_req_nullify,
   output logic err_uncorr_internal,
   // Request progress
   output logic [5:0] req_progress_tag_out_a,
   output logic req_progress_valid_a,
   output logic [5:0] req_progress_tag_out_b,
   output logic req_progress_valid_b,
   // Completions from the core's buffer
   input wire logic cpl_in_valid,
   output logic cpl_in_ready,
   input wire logic [511:0] cpl_in_payload,
   input wire logic cpl_in_last,
   input wire logic [4:0] cpl_in_dword_count,
   input wire logic [63:0] cpl_in_byte_en,
   input wire logic cpl_in_buf_err,
   // Completion stream to user logic
   output logic [511:0] cpl_out_payload,
   output logic [160:0] cpl_out_sideband,
   output logic cpl_out_last,
   output logic [15:0] cpl_out_dword_keep,
   output logic cpl_out_valid,
   input wire logic cpl_out_ready
);
   localparam int BW = rss_pkg::BEAT_W;
   localparam int SB = rss_pkg::CPL_SB_W;
   localparam int DW = rss_pkg::DATA_W;
   localparam int KW = rss_pkg::DWORDS;
   // Contiguous dword mask from a count of 1 to 16
   function automatic logic [15:0] keep_mask(input logic [4:0] n);
      logic [15:0] m;
      m = 16'h0000;
      for (int i = 0; i < rss_pkg::DWORDS; i++) begin
         m[i] = (5'(i) < n);
      end
      return m;
   endfunction
   logic [1:0] ctrl_q;
   logic par_err_q;
   logic cpl_disc_q;
   logic [15:0] null_cnt_q;
   logic [15:0] cpl_cnt_q;
   logic wait_q;
   logic [31:0] rdata_q;
   wire bus_req = avs_read | avs_write;
   wire bus_take = bus_req & ~wait_q;
   wire wr_take = avs_write & ~wait_q;
   wire sel_ctrl = (avs_address == rss_pkg::OFS_CTRL);
   wire sel_status = (avs_address == rss_pkg::OFS_STATUS);
   wire straddle_en = ctrl_q[rss_pkg::CTRL_STRADDLE];
   wire parity_en = ctrl_q[rss_pkg::CTRL_PARITY];
   wire st_clr_par = wr_take & sel_status &
      avs_writedata[rss_pkg::ST_PAR_ERR];
   wire st_clr_disc = wr_take & sel_status &
      avs_writedata[rss_pkg::ST_CPL_DISC];
   logic [31:0] rd_mux;
   always_comb begin
      if (avs_address == rss_pkg::OFS_CTRL) begin
         rd_mux = {30'h0, ctrl_q};
      end else if (avs_address == rss_pkg::OFS_STATUS) begin
         rd_mux = {30'h0, cpl_disc_q, par_err_q};
      end else if (avs_address == rss_pkg::OFS_NULL_CNT) begin
         rd_mux = {16'h0, null_cnt_q};
      end else if (avs_address == rss_pkg::OFS_CPL_CNT) begin
         rd_mux = {16'h0, cpl_cnt_q};
      end else begin
         rd_mux = 32'h0;
      end
   end

   // One idle cycle of waitrequest, then the access completes
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
      end else if (bus_req && wait_q) begin
         wait_q <= 1'b0;
         rdata_q <= rd_mux;
      end else begin
         wait_q <= 1'b1;
      end
   end

   // Options are meant to be set before traffic; no in-flight guard
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl_q <= rss_pkg::CTRL_RESET;
      end else if (wr_take && sel_ctrl) begin
         ctrl_q <= avs_writedata[1:0];
      end
   end
   logic [63:0] req_par_calc;
   rss_byte_parity u_req_par (
      .data(req_in_payload),
      .parity(req_par_calc)
   );
   logic req_ready_q;
   logic stage_full_q;
   logic in_pkt_q;
   logic bad_pkt_q;
   logic err_q;
   logic [DW-1:0] st_data_q;
   logic [182:0] st_sb_q;
   logic st_last_q;
   logic st_null_q;
   logic st_sop_q;
   logic st_dual_q;
   logic [5:0] st_tag_a_q;
   logic [5:0] st_tag_b_q;
   logic [5:0] prog_a_q;
   logic [5:0] prog_b_q;
   logic prog_va_q;
   logic prog_vb_q;
   wire req_take = req_in_valid & req_ready_q;
   wire req_drain = stage_full_q & link_req_ready;
   wire req_first = req_take & ~in_pkt_q;
   wire [5:0] tag_b_in = req_in_sideband[rss_pkg::RQ_TAG1_LO +: 6];
   wire [63:0] par_in = req_in_sideband[rss_pkg::RQ_PAR_LO +: 64];
   wire par_bad = parity_en & (par_in != req_par_calc);
   wire pkt_bad = bad_pkt_q | par_bad;
   wire stage_next = req_take | (stage_full_q & ~link_req_ready);
   wire new_err = req_take & par_bad & ~bad_pkt_q;
   // Single holding stage; ready is registered so it is dropped while full
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         req_ready_q <= 1'b0;
         stage_full_q <= 1'b0;
      end else begin
         req_ready_q <= ~stage_next;
         stage_full_q <= stage_next;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         in_pkt_q <= 1'b0;
         bad_pkt_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         err_q <= new_err;
         if (req_take) begin
            in_pkt_q <= ~req_in_last;
            bad_pkt_q <= pkt_bad & ~req_in_last;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_data_q <= '0;
         st_sb_q <= '0;
         st_last_q <= 1'b0;
         st_null_q <= 1'b0;
         st_sop_q <= 1'b0;
         st_dual_q <= 1'b0;
         st_tag_a_q <= 6'h0;
         st_tag_b_q <= 6'h0;
      end else if (req_take) begin
         st_data_q <= req_in_payload;
         st_sb_q <= req_in_sideband;
         st_last_q <= req_in_last;
         st_null_q <= req_in_last & pkt_bad;
         st_sop_q <= req_first;
         st_dual_q <= req_first & req_in_dual_start & straddle_en;
         if (req_first) begin
            st_tag_a_q <= req_tag_first;
            st_tag_b_q <= tag_b_in;
         end
      end else if (req_drain) begin
         // Nullify must not linger once the marked beat has left
         st_null_q <= 1'b0;
      end
   end

   // Once the link has the first beat nothing can overtake the request
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prog_a_q <= 6'h0;
         prog_b_q <= 6'h0;
         prog_va_q <= 1'b0;
         prog_vb_q <= 1'b0;
      end else begin
         prog_va_q <= req_drain & st_sop_q;
         prog_vb_q <= req_drain & st_dual_q;
         if (req_drain && st_sop_q) begin
            prog_a_q <= st_tag_a_q;
            prog_b_q <= st_tag_b_q;
         end
      end
   end
   logic [63:0] cpl_par_calc;
   rss_byte_parity u_cpl_par (
      .data(cpl_in_payload),
      .parity(cpl_par_calc)
   );

   logic cpl_ready_q;
   logic out_valid_q;
   logic skid_full_q;
   logic [BW-1:0] out_q;
   logic [BW-1:0] skid_q;
   logic cpl_in_pkt_q;
   logic cpl_err_q;

   wire cpl_take = cpl_in_valid & cpl_ready_q;
   wire cpl_pop = out_valid_q & cpl_out_ready;
   wire cpl_sop = ~cpl_in_pkt_q;
   wire cpl_disc = cpl_in_last & (cpl_err_q | cpl_in_buf_err);
   wire [3:0] eop_ptr = 4'(cpl_in_dword_count - 5'h1);

   // Format one beat's sideband, keep and last from the source beat
   wire [3:0] f_sop = straddle_en ?
      (cpl_sop ? rss_pkg::THERM_ONE : rss_pkg::THERM_NONE) :
      {3'h0, cpl_sop};
   wire [3:0] f_eop = (straddle_en && cpl_in_last) ?
      rss_pkg::THERM_ONE : rss_pkg::THERM_NONE;
   wire [3:0] f_eop_ptr = (straddle_en && cpl_in_last) ? eop_ptr : 4'h0;
   wire [1:0] f_lane = rss_pkg::LANE_ZERO;
   wire [15:0] f_keep = straddle_en ? rss_pkg::KEEP_ALL :
      keep_mask(cpl_in_dword_count);
   wire f_last = cpl_in_last & ~straddle_en;

   logic [SB-1:0] f_sb;
   always_comb begin
      f_sb = '0;
      f_sb[rss_pkg::CS_BE_LO +: 64] = cpl_in_byte_en;
      f_sb[rss_pkg::CS_SOP_LO +: 4] = f_sop;
      f_sb[rss_pkg::CS_SOP0_PTR_LO +: 2] = f_lane;
      f_sb[rss_pkg::CS_EOP_LO +: 4] = f_eop;
      f_sb[rss_pkg::CS_EOP0_PTR_LO +: 4] = f_eop_ptr;
      f_sb[rss_pkg::CS_DISC] = cpl_disc;
      f_sb[rss_pkg::CS_PAR_LO +: 64] = cpl_par_calc;
   end

   wire [BW-1:0] f_beat = {f_sb, f_keep, f_last, cpl_in_payload};
   wire skid_next = skid_full_q ? ~cpl_pop :
      (cpl_take & out_valid_q & ~cpl_pop);

   // Error seen anywhere in a packet is reported on its last beat
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cpl_in_pkt_q <= 1'b0;
         cpl_err_q <= 1'b0;
      end else if (cpl_take) begin
         cpl_in_pkt_q <= ~cpl_in_last;
         cpl_err_q <= (cpl_err_q | cpl_in_buf_err) & ~cpl_in_last;
      end
   end

   // Two-entry skid: registered ready, and a steady stream keeps valid up
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cpl_ready_q <= 1'b0;
         out_valid_q <= 1'b0;
         skid_full_q <= 1'b0;
         out_q <= '0;
         skid_q <= '0;
      end else begin
         cpl_ready_q <= ~skid_next;
         skid_full_q <= skid_next;
         if (skid_full_q) begin
            if (cpl_pop) begin
               out_q <= skid_q;
            end
         end else if (cpl_take) begin
            if (!out_valid_q || cpl_pop) begin
               out_q <= f_beat;
               out_valid_q <= 1'b1;
            end else begin
               skid_q <= f_beat;
            end
         end else if (cpl_pop) begin
            out_valid_q <= 1'b0;
         end
      end
   end
   wire disc_out = cpl_pop & out_q[DW + 1 + KW + rss_pkg::CS_DISC];
   wire last_out = cpl_pop & (straddle_en ?
      out_q[DW + 1 + KW + rss_pkg::CS_EOP_LO] : out_q[DW]);
   wire null_out = req_drain & st_null_q;

   // A new event in the clearing cycle keeps its bit set
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         par_err_q <= 1'b0;
         cpl_disc_q <= 1'b0;
         null_cnt_q <= 16'h0;
         cpl_cnt_q <= 16'h0;
      end else begin
         par_err_q <= new_err | (par_err_q & ~st_clr_par);
         cpl_disc_q <= disc_out | (cpl_disc_q & ~st_clr_disc);
         if (null_out) begin
            null_cnt_q <= null_cnt_q + 16'h1;
         end
         if (last_out) begin
            cpl_cnt_q <= cpl_cnt_q + 16'h1;
         end
      end
   end
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign req_in_ready = req_ready_q;
   assign link_req_valid = stage_full_q;
   assign link_req_payload = st_data_q;
   assign link_req_sideband = st_sb_q;
   assign link_req_last = st_last_q;
   assign link_req_nullify = st_null_q;
   assign err_uncorr_internal = err_q;
   assign req_progress_tag_out_a = prog_a_q;
   assign req_progress_valid_a = prog_va_q;
   assign req_progress_tag_out_b = prog_b_q;
   assign req_progress_valid_b = prog_vb_q;
   assign cpl_in_ready = cpl_ready_q;
   assign cpl_out_payload = out_q[DW-1:0];
   assign cpl_out_last = out_q[DW];
   assign cpl_out_dword_keep = out_q[DW + 1 +: KW];
   assign cpl_out_sideband = out_q[DW + 1 + KW +: SB];
   assign cpl_out_valid = out_valid_q;
endmodule

// *** hdl/rss_pkg.sv ***
// Constants and field layout for the requester stream sideband block
package rss_pkg;
   localparam int DATA_W = 512;
   localparam int BYTES = 64;
   localparam int DWORDS = 16;
   localparam int REQ_SB_W = 183;
   localparam int CPL_SB_W = 161;
   localparam int TAG_W = 6;
   localparam int CNT_W = 16;

   // Request sideband field positions
   localparam int RQ_TAG1_LO = 67;
   localparam int RQ_PAR_LO = 73;
   localparam int RQ_PASID_V0 = 137;
   localparam int RQ_PASID_V1 = 138;
   localparam int RQ_PASID0_LO = 139;
   localparam int RQ_PASID1_LO = 159;
   localparam int RQ_EXEC0 = 179;
   localparam int RQ_EXEC1 = 180;
   localparam int RQ_PRIV0 = 181;
   localparam int RQ_PRIV1 = 182;

   // Completion sideband field positions
   localparam int CS_BE_LO = 0;
   localparam int CS_SOP_LO = 64;
   localparam int CS_SOP0_PTR_LO = 68;
   localparam int CS_EOP_LO = 76;
   localparam int CS_EOP0_PTR_LO = 80;
   localparam int CS_DISC = 96;
   localparam int CS_PAR_LO = 97;

   // Stored completion beat: sideband, keep, last, data
   localparam int BEAT_W = CPL_SB_W + DWORDS + 1 + DATA_W;

   localparam logic [3:0] THERM_NONE = 4'h0;
   localparam logic [3:0] THERM_ONE = 4'h1;
   localparam logic [1:0] LANE_ZERO = 2'h0;
   localparam logic [15:0] KEEP_ALL = 16'hFFFF;

   // Register map, byte offsets on the Avalon word bus
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_NULL_CNT = 4'h8;
   localparam logic [3:0] OFS_CPL_CNT = 4'hC;
   localparam int CTRL_STRADDLE = 0;
   localparam int CTRL_PARITY = 1;
   localparam int ST_PAR_ERR = 0;
   localparam int ST_CPL_DISC = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
endpackage

// *** hdl/rss_byte_parity.sv ***
// Odd parity per byte of a 512-bit data word
`timescale 1ns/1ps
module rss_byte_parity (
   input wire logic [511:0] data,
   output logic [63:0] parity
);
   genvar i;
   generate
      for (i = 0; i < rss_pkg::BYTES; i++) begin : g_byte
         assign parity[i] = ~^data[8*i +: 8];
      end
   endgenerate
endmodule

// *** tb/rss_stream_props.sv ***
// Checker of completion stream and link request rules
`timescale 1ns/1ps
module rss_stream_props (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [511:0] cpl_out_payload,
   input wire logic [160:0] cpl_out_sideband,
   input wire logic cpl_out_last,
   input wire logic [15:0] cpl_out_dword_keep,
   input wire logic cpl_out_valid,
   input wire logic cpl_out_ready,
   input wire logic link_req_valid,
   input wire logic link_req_last,
   input wire logic link_req_nullify
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   logic [63:0] par_w;
   logic [15:0] keep_inc;
   logic after_last_q;
   assign keep_inc = cpl_out_dword_keep + 16'h1;
   always_comb begin
      for (int i = 0; i < 64; i++) begin
         par_w[i] = ~^cpl_out_payload[8*i +: 8];
      end
   end
   // A start is due on the first beat after reset or after a packet end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         after_last_q <= 1'b1;
      end else if (cpl_out_valid && cpl_out_ready) begin
         after_last_q <= cpl_out_last || cpl_out_sideband[76];
      end
   end
   cpl_hold_a: assert property (cpl_out_valid && !cpl_out_ready |=>
      cpl_out_valid && $stable(cpl_out_payload) && $stable(cpl_out_sideband))
      else $error("completion beat changed while stalled");
   sop_code_a: assert property (cpl_out_valid |->
      cpl_out_sideband[67:64] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
      else $error("reserved start code");
   eop_code_a: assert property (cpl_out_valid |->
      cpl_out_sideband[79:76] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
      else $error("reserved end code");
   lane_zero_a: assert property (cpl_out_valid |->
      cpl_out_sideband[69:68] == 2'h0) else $error("start lane not zero");
   keep_contig_a: assert property (cpl_out_valid |->
      cpl_out_dword_keep != 16'h0 && (cpl_out_dword_keep & keep_inc) == 16'h0)
      else $error("keep not contiguous from dword zero");
   keep_full_a: assert property (cpl_out_valid && !cpl_out_last |->
      cpl_out_dword_keep == 16'hFFFF) else $error("keep short before end");
   disc_last_a: assert property (cpl_out_valid && cpl_out_sideband[96] |->
      cpl_out_last || cpl_out_sideband[76]) else $error("discard off end");
   parity_ok_a: assert property (cpl_out_valid |->
      cpl_out_sideband[160:97] == par_w) else $error("payload parity wrong");
   start_after_a: assert property (cpl_out_valid && after_last_q |->
      cpl_out_sideband[64]) else $error("packet start not flagged");
   null_last_a: assert property (link_req_nullify |->
      link_req_valid && link_req_last) else $error("nullify off last beat");
endmodule
bind rss_stream_core rss_stream_props rss_stream_props_i (
   .core_clk(core_clk), .reset(reset), .cpl_out_payload(cpl_out_payload),
   .cpl_out_sideband(cpl_out_sideband), .cpl_out_last(cpl_out_last),
   .cpl_out_dword_keep(cpl_out_dword_keep), .cpl_out_valid(cpl_out_valid),
   .cpl_out_ready(cpl_out_ready), .link_req_valid(link_req_valid),
   .link_req_last(link_req_last), .link_req_nullify(link_req_nullify));

// *** tb/rss_user_model.sv ***
// Far-side user logic model: completion sink and link sink with stalls
`timescale 1ns/1ps
module rss_user_model (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic stall,
   output logic cpl_out_ready,
   output logic link_req_ready
);
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   assign cnt_d = cnt_q + 2'h1;
   // Ready drops while valid may be high, so held beats get exercised
   assign cpl_out_ready = !(stall && cnt_q[1]);
   assign link_req_ready = !(stall && cnt_q == 2'h0);
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

// *** tb/rss_stream_core_bench.sv ***
// Testbench for the requester stream sideband block
`timescale 1ns/1ps
module rss_stream_core_bench;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic req_in_valid = 1'b0;
   logic req_in_ready;
   logic [511:0] req_in_payload = {16{32'hA5C3_0F1E}};
   logic [182:0] req_in_sideband = '0;
   logic req_in_last = 1'b0;
   logic req_in_dual_start = 1'b0;
   logic [5:0] req_tag_first = 6'h0;
   logic link_req_valid, link_req_ready, link_req_last, link_req_nullify;
   logic err_uncorr_internal, pv_a, pv_b;
   logic [5:0] tag_a, tag_b;
   logic [182:0] link_sb, last_sb;
   logic [63:0] cpl_be = 64'h0000_0000_0000_0FFF;
   logic [31:0] last_be = 32'h0;
   logic cpl_in_valid = 1'b0;
   logic cpl_in_ready;
   logic [511:0] cpl_in_payload = {16{32'h1234_5678}};
   logic cpl_in_last = 1'b0;
   logic [4:0] cpl_in_dword_count = 5'h1;
   logic cpl_in_buf_err = 1'b0;
   logic [511:0] cpl_out_payload;
   logic [160:0] cpl_out_sideband;
   logic cpl_out_last, cpl_out_valid, cpl_out_ready;
   logic [15:0] cpl_out_dword_keep;
   logic stall = 1'b0;
   int err_total = 0;
   int checked = 0;
   int n_null = 0;
   int n_err = 0;
   int n_pa = 0;
   logic [5:0] seen_a = 6'h0;
   logic [5:0] seen_b = 6'h0;
   logic [31:0] beats[$];
   logic [31:0] rd;
   always #4 core_clk = ~core_clk;
   rss_stream_core rss_stream_core_i (.core_clk(core_clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .req_in_valid(req_in_valid),
      .req_in_ready(req_in_ready), .req_in_payload(req_in_payload),
      .req_in_sideband(req_in_sideband), .req_in_last(req_in_last),
      .req_in_dual_start(req_in_dual_start), .req_tag_first(req_tag_first),
      .link_req_valid(link_req_valid), .link_req_ready(link_req_ready),
      .link_req_payload(), .link_req_sideband(link_sb),
      .link_req_last(link_req_last), .link_req_nullify(link_req_nullify),
      .err_uncorr_internal(err_uncorr_internal),
      .req_progress_tag_out_a(tag_a), .req_progress_valid_a(pv_a),
      .req_progress_tag_out_b(tag_b), .req_progress_valid_b(pv_b),
      .cpl_in_valid(cpl_in_valid), .cpl_in_ready(cpl_in_ready),
      .cpl_in_payload(cpl_in_payload), .cpl_in_last(cpl_in_last),
      .cpl_in_dword_count(cpl_in_dword_count), .cpl_in_byte_en(cpl_be),
      .cpl_in_buf_err(cpl_in_buf_err), .cpl_out_payload(cpl_out_payload),
      .cpl_out_sideband(cpl_out_sideband), .cpl_out_last(cpl_out_last),
      .cpl_out_dword_keep(cpl_out_dword_keep), .cpl_out_valid(cpl_out_valid),
      .cpl_out_ready(cpl_out_ready));
   rss_user_model rss_user_model_i (.core_clk(core_clk), .reset(reset),
      .stall(stall), .cpl_out_ready(cpl_out_ready),
      .link_req_ready(link_req_ready));
   always @(posedge core_clk) begin
      if (link_req_valid && link_req_ready && link_req_nullify) n_null++;
      if (err_uncorr_internal === 1'b1) n_err++;
      if (pv_a === 1'b1) n_pa++;
      if (pv_a === 1'b1) seen_a = tag_a;
      if (pv_b === 1'b1) seen_b = tag_b;
      if (link_req_valid && link_req_ready) last_sb = link_sb;
      if (cpl_out_valid && cpl_out_ready) last_be = cpl_out_sideband[31:0];
      if (cpl_out_valid && cpl_out_ready) beats.push_back({cpl_out_sideband[96],
         cpl_out_last, 2'h0, cpl_out_sideband[83:76], cpl_out_sideband[67:64],
         cpl_out_dword_keep});
   end
   task automatic tk(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      tk(1);
   endtask
   function automatic logic [63:0] par(input logic [511:0] d);
      for (int i = 0; i < 64; i++) par[i] = ~^d[8*i +: 8];
   endfunction
   task automatic req(input logic [5:0] t1, input logic [5:0] t2,
                      input logic lst, input logic dual, input logic bad);
      req_tag_first <= t1;
      req_in_sideband <= {46'h15A5A5A5A5A, par(req_in_payload) ^ {63'h0, bad},
         t2, 67'h0};
      req_in_last <= lst;
      req_in_dual_start <= dual;
      req_in_valid <= 1'b1;
      do @(posedge core_clk); while (req_in_ready !== 1'b1);
      req_in_valid <= 1'b0;
      tk(1);
   endtask
   task automatic cpl(input logic lst, input logic [4:0] n, input logic be);
      cpl_in_last <= lst;
      cpl_in_dword_count <= n;
      cpl_in_buf_err <= be;
      cpl_in_valid <= 1'b1;
      do @(posedge core_clk); while (cpl_in_ready !== 1'b1);
      if (lst) cpl_in_valid <= 1'b0;
      if (lst) tk(1);
   endtask
   function automatic logic [31:0] bt(input logic ds, input logic lst,
      input logic [7:0] e, input logic [3:0] s, input logic [15:0] k);
      return {ds, lst, 2'h0, e, s, k};
   endfunction
   task automatic summarize();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      summarize();
   end
   initial begin
      tk(6);
      reset <= 1'b0;
      tk(1);
      bus(1'b1, 4'h2, 32'hFFFF_FFFF);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'b0, rss_pkg::OFS_CTRL, 32'h0);
      chk("ctrl_reset", {30'h0, rss_pkg::CTRL_RESET}, rd);
      req(6'h15, 6'h0, 1'b0, 1'b0, 1'b0);
      req(6'h3F, 6'h0, 1'b1, 1'b0, 1'b0);
      chk("tag_a", 32'h15, seen_a);
      req(6'h00, 6'h0, 1'b1, 1'b0, 1'b1);
      tk(8);
      chk("tag_a_zero", 32'h00, seen_a);
      chk("tag_a_count", 32'h2, n_pa);
      chk("null_parity_off", 32'h0, n_null);
      bus(1'b1, rss_pkg::OFS_CTRL, 32'h2);
      stall <= 1'b1;
      req(6'h01, 6'h0, 1'b1, 1'b0, 1'b0);
      req(6'h02, 6'h0, 1'b0, 1'b0, 1'b1);
      req(6'h03, 6'h0, 1'b1, 1'b0, 1'b0);
      tk(8);
      chk("nullified", 32'h1, n_null);
      chk("internal_err", 32'h1, n_err);
      bus(1'b0, rss_pkg::OFS_STATUS, 32'h0);
      chk("par_err_flag", 32'h1, rd & 32'h1);
      bus(1'b1, rss_pkg::OFS_STATUS, 32'h1);
      bus(1'b0, rss_pkg::OFS_STATUS, 32'h0);
      chk("par_err_clear", 32'h0, rd & 32'h1);
      bus(1'b0, rss_pkg::OFS_NULL_CNT, 32'h0);
      chk("null_cnt", 32'h1, rd);
      cpl(1'b0, 5'h10, 1'b0);
      cpl(1'b1, 5'h03, 1'b0);
      cpl(1'b1, 5'h01, 1'b1);
      tk(20);
      chk("cpl_count", 32'h3, beats.size());
      chk("beat0", bt(0, 0, 8'h00, 4'h1, 16'hFFFF), beats.pop_front());
      chk("beat1", bt(0, 1, 8'h00, 4'h0, 16'h0007), beats.pop_front());
      chk("beat2", bt(1, 1, 8'h00, 4'h1, 16'h0001), beats.pop_front());
      bus(1'b0, rss_pkg::OFS_STATUS, 32'h0);
      chk("discard_flag", 32'h2, rd & 32'h2);
      chk("byte_en", 32'h0FFF, last_be);
      bus(1'b0, rss_pkg::OFS_CPL_CNT, 32'h0);
      chk("cpl_cnt_reg", 32'h2, rd);
      bus(1'b1, rss_pkg::OFS_CTRL, 32'h1);
      req(6'h07, 6'h2A, 1'b1, 1'b1, 1'b0);
      tk(8);
      chk("tag_a_dual", 32'h07, seen_a);
      chk("tag_b_dual", 32'h2A, seen_b);
      chk("prefix_pass", 32'h5A5A_5A5A, last_sb[168:137]);
      cpl(1'b1, 5'h03, 1'b0);
      cpl(1'b0, 5'h10, 1'b1);
      cpl(1'b1, 5'h05, 1'b0);
      tk(20);
      chk("cpl_count_s", 32'h3, beats.size());
      chk("beat3", bt(0, 0, 8'h21, 4'h1, 16'hFFFF), beats.pop_front());
      chk("beat4", bt(0, 0, 8'h00, 4'h1, 16'hFFFF), beats.pop_front());
      chk("beat5", bt(1, 0, 8'h41, 4'h0, 16'hFFFF), beats.pop_front());
      bus(1'b0, rss_pkg::OFS_CPL_CNT, 32'h0);
      chk("cpl_cnt_str", 32'h4, rd);
      summarize();
   end
endmodule
